/* hdl/cpbc_pkg.sv */
// Package: offsets, field positions, reset values and timing for the protection/boost option registers
package cpbc_pkg;
   // Register offsets on the command bus (documented byte commands)
   localparam logic [7:0]  CPBC_ADDR_OPT3     = 8'h37;
   localparam logic [7:0]  CPBC_ADDR_THR0     = 8'h3c;
   // Option three field positions
   localparam int          CPBC_B_ADAPTER_OVERCURRENT_EN     = 10;
   localparam int          CPBC_B_ADAPTER_OVERCURRENT_LIM    = 9;
   localparam int          CPBC_B_HS_SHORT    = 7;
   localparam int          CPBC_B_LS_SHORT    = 6;
   localparam int          CPBC_B_FAST_THR    = 5;
   localparam int          CPBC_B_RESP_HI     = 4;
   localparam int          CPBC_B_RESP_LO     = 3;
   localparam int          CPBC_B_BOOST_EN    = 2;
   localparam int          CPBC_B_BOOST_STAT  = 1;
   // Writable bits of the covered low eleven bits; bit 1 is status, 0 and 8 reserved
   localparam logic [15:0] CPBC_OPT3_WMASK    = 16'h06fc;
   localparam logic [15:0] CPBC_OPT3_RST      = 16'h0240;
   // Throttle option zero: critical level field and writable mask
   localparam int          CPBC_CRIT_MSB      = 15;
   localparam int          CPBC_CRIT_LSB      = 11;
   localparam logic [15:0] CPBC_THR0_WMASK    = 16'hfefe;
   localparam logic [15:0] CPBC_THR0_RST      = 16'h4a54;
   localparam logic [4:0]  CPBC_CRIT_RST      = 5'h09;
   // Response time codes
   localparam logic [1:0]  CPBC_RESP_150      = 2'h0;
   localparam logic [1:0]  CPBC_RESP_250      = 2'h1;
   // Response times in microseconds and clock rate
   localparam int          CPBC_CLK_MHZ       = 100;
   localparam int          CPBC_T150_US       = 150;
   localparam int          CPBC_T250_US       = 250;
   localparam int          CPBC_T50_US        = 50;
   localparam int          CPBC_CNT150        = CPBC_T150_US * CPBC_CLK_MHZ;
   localparam int          CPBC_CNT250        = CPBC_T250_US * CPBC_CLK_MHZ;
   localparam int          CPBC_CNT50         = CPBC_T50_US * CPBC_CLK_MHZ;
   localparam int          CPBC_CNT_W         = 15;
   typedef enum logic [1:0] {CPBC_IDLE, CPBC_WAIT, CPBC_BOOST} cpbc_state_t;
endpackage : cpbc_pkg

/* hdl/cpbc_regs.sv */
// Register storage for the two option words with masked writes and read-out register
`timescale 1ns/1ps
module cpbc_regs
   import cpbc_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        nrst,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   input  wire logic [7:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        boost_clr,
   input  wire logic        boost_stat,
   output logic      [15:0] opt3_q,
   output logic      [15:0] thr0_q,
   output logic      [15:0] rdata_q
);
   logic [15:0] opt3_ff, nxt_opt3;
   logic [15:0] thr0_ff, nxt_thr0;
   logic [15:0] rdata_ff, nxt_rdata;

   // Masked writes; battery removal clears the boost enable and wins over a write
   always_comb begin
      nxt_opt3  = opt3_ff;
      nxt_thr0  = thr0_ff;
      nxt_rdata = rdata_ff;
      if (wr_en && addr == CPBC_ADDR_OPT3) begin
         nxt_opt3 = wdata & CPBC_OPT3_WMASK;
      end
      if (wr_en && addr == CPBC_ADDR_THR0) begin
         nxt_thr0 = wdata & CPBC_THR0_WMASK;
      end
      if (boost_clr) begin
         nxt_opt3[CPBC_B_BOOST_EN] = 1'b0;
      end
      if (rd_en) begin
         case (addr)
            CPBC_ADDR_OPT3: begin
               nxt_rdata = opt3_ff;
               nxt_rdata[CPBC_B_BOOST_STAT] = boost_stat;
            end
            CPBC_ADDR_THR0: nxt_rdata = thr0_ff;
            default:        nxt_rdata = 16'h0000;
         endcase
      end
   end

   // Power-on defaults
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         opt3_ff  <= CPBC_OPT3_RST;
         thr0_ff  <= CPBC_THR0_RST;
         rdata_ff <= 16'h0000;
      end else begin
         opt3_ff  <= nxt_opt3;
         thr0_ff  <= nxt_thr0;
         rdata_ff <= nxt_rdata;
      end
   end

   assign opt3_q  = opt3_ff;
   assign thr0_q  = thr0_ff;
   assign rdata_q = rdata_ff;

   AST_CRIT_RST: assert property (@(posedge clock) $rose(nrst) |-> thr0_ff[CPBC_CRIT_MSB:CPBC_CRIT_LSB] == CPBC_CRIT_RST)
      else $error("critical level default wrong");
   AST_RSVD_ZERO: assert property (@(posedge clock) disable iff (!nrst)
      (opt3_ff & ~CPBC_OPT3_WMASK) == 16'h0000 && (thr0_ff & ~CPBC_THR0_WMASK) == 16'h0000)
      else $error("reserved bit set");
endmodule : cpbc_regs

/* hdl/cpbc_top.sv */
// Protection and hybrid boost configuration block: registers, fault gating and boost entry timing
`timescale 1ns/1ps
module cpbc_top
   import cpbc_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        nrst,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   input  wire logic [7:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        battery_present_n,
   input  wire logic        fast_load_over,
   input  wire logic        adapter_overcurrent_cmp,
   input  wire logic        high_side_short_cmp,
   input  wire logic        low_side_short_cmp,
   output logic      [15:0] rdata,
   output logic             adapter_overcurrent_limit_sel,
   output logic             fast_load_threshold_sel,
   output logic      [4:0]  critical_input_current,
   output logic             adapter_overcurrent_fault,
   output logic             high_side_short_fault,
   output logic             low_side_short_fault,
   output logic             cycle_limit_active,
   output logic             boost_active
);
   cpbc_state_t             state_ff, nxt_state;
   logic [CPBC_CNT_W-1:0]   cnt_ff, nxt_cnt;
   logic                    batp_ff;
   logic                    boost_ff;
   logic                    aoc_ff, hs_ff, ls_ff, cyc_ff, lim_ff, fthr_ff;
   logic [4:0]              crit_ff;
   logic [15:0]             opt3, thr0;
   logic                    boost_clr;
   logic                    boost_en;
   logic [CPBC_CNT_W-1:0]   resp_cnt;

   // The wait counter must hold the longest response count or boost entry would wrap early
   if (CPBC_CNT250 > (2 ** CPBC_CNT_W) - 1) begin : g_cnt_chk
      $error("response counter too narrow");
   end

   // Battery removal edge; one register of history is enough since input is synchronous
   assign boost_clr = battery_present_n & ~batp_ff;
   assign boost_en  = opt3[CPBC_B_BOOST_EN];

   cpbc_regs u_regs (
      .clock      (clock),
      .nrst       (nrst),
      .wr_en      (wr_en),
      .rd_en      (rd_en),
      .addr       (addr),
      .wdata      (wdata),
      .boost_clr  (boost_clr),
      .boost_stat (state_ff == CPBC_BOOST),
      .opt3_q     (opt3),
      .thr0_q     (thr0),
      .rdata_q    (rdata)
   );

   // Response delay selected by the two-bit field; 1X maps to the shortest
   always_comb begin
      case (opt3[CPBC_B_RESP_HI:CPBC_B_RESP_LO])
         CPBC_RESP_150: resp_cnt = CPBC_CNT_W'(CPBC_CNT150 - 1);
         CPBC_RESP_250: resp_cnt = CPBC_CNT_W'(CPBC_CNT250 - 1);
         default:       resp_cnt = CPBC_CNT_W'(CPBC_CNT50 - 1);
      endcase
   end

   // Boost entry: wait the response time with the load over threshold, leave when it drops
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      case (state_ff)
         CPBC_IDLE: begin
            nxt_cnt = '0;
            if (boost_en && fast_load_over) begin
               nxt_state = CPBC_WAIT;
            end
         end
         CPBC_WAIT: begin
            if (!boost_en || !fast_load_over) begin
               nxt_state = CPBC_IDLE;
               nxt_cnt   = '0;
            end else if (cnt_ff >= resp_cnt) begin
               nxt_state = CPBC_BOOST;
            end else begin
               nxt_cnt = cnt_ff + 1'b1;
            end
         end
         CPBC_BOOST: begin
            nxt_cnt = '0;
            // Falling hysteresis level is applied by the comparator itself
            if (!boost_en || !fast_load_over) begin
               nxt_state = CPBC_IDLE;
            end
         end
         default: begin
            nxt_state = CPBC_IDLE;
            nxt_cnt   = '0;
         end
      endcase
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_ff <= CPBC_IDLE;
         cnt_ff   <= '0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
      end
   end

   // Fault gating and threshold selects, all registered so outputs come from flops
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         batp_ff <= 1'b0;
         boost_ff <= 1'b0;
         aoc_ff  <= 1'b0;
         hs_ff   <= 1'b0;
         ls_ff   <= 1'b0;
         cyc_ff  <= 1'b0;
         lim_ff  <= 1'b1;
         fthr_ff <= 1'b0;
         crit_ff <= CPBC_CRIT_RST;
      end else begin
         batp_ff <= battery_present_n;
         boost_ff <= (nxt_state == CPBC_BOOST);
         aoc_ff  <= opt3[CPBC_B_ADAPTER_OVERCURRENT_EN] & adapter_overcurrent_cmp;
         hs_ff   <= opt3[CPBC_B_HS_SHORT] & high_side_short_cmp;
         ls_ff   <= opt3[CPBC_B_LS_SHORT] & low_side_short_cmp;
         cyc_ff  <= opt3[CPBC_B_LS_SHORT] & (nxt_state == CPBC_BOOST);
         lim_ff  <= opt3[CPBC_B_ADAPTER_OVERCURRENT_LIM];
         fthr_ff <= opt3[CPBC_B_FAST_THR];
         crit_ff <= thr0[CPBC_CRIT_MSB:CPBC_CRIT_LSB];
      end
   end

   assign adapter_overcurrent_limit_sel = lim_ff;
   assign fast_load_threshold_sel       = fthr_ff;
   assign critical_input_current        = crit_ff;
   assign adapter_overcurrent_fault     = aoc_ff;
   assign high_side_short_fault         = hs_ff;
   assign low_side_short_fault          = ls_ff;
   assign cycle_limit_active            = cyc_ff;
   // Own flop mirrors the boost state so the pin carries no decode glitches
   assign boost_active                  = boost_ff;

   AST_BATT_CLR: assert property (@(posedge clock) disable iff (!nrst)
      $rose(battery_present_n) |=> !boost_en)
      else $error("boost enable not cleared on removal");
   AST_NO_EARLY_BOOST: assert property (@(posedge clock) disable iff (!nrst)
      $rose(state_ff == CPBC_WAIT) && opt3[CPBC_B_RESP_HI] |-> !boost_active [*8])
      else $error("boost entered too early");
   AST_BOOST_NEEDS_EN: assert property (@(posedge clock) disable iff (!nrst)
      boost_active |-> $past(boost_en))
      else $error("boost without enable");
   AST_ADAPTER_OVERCURRENT_GATE: assert property (@(posedge clock) disable iff (!nrst)
      !opt3[CPBC_B_ADAPTER_OVERCURRENT_EN] |=> !adapter_overcurrent_fault)
      else $error("overcurrent fault while disabled");
   AST_HS_GATE: assert property (@(posedge clock) disable iff (!nrst)
      opt3[CPBC_B_HS_SHORT] && high_side_short_cmp |=> high_side_short_fault)
      else $error("high side short missed");
   AST_LS_GATE: assert property (@(posedge clock) disable iff (!nrst)
      !opt3[CPBC_B_LS_SHORT] |=> !low_side_short_fault)
      else $error("low side fault while disabled");
   AST_CYC: assert property (@(posedge clock) disable iff (!nrst)
      cycle_limit_active |-> boost_active)
      else $error("cycle limit outside boost");
   AST_LIM: assert property (@(posedge clock) disable iff (!nrst)
      ##1 adapter_overcurrent_limit_sel == $past(opt3[CPBC_B_ADAPTER_OVERCURRENT_LIM]))
      else $error("limit select not following register");
   AST_FTHR: assert property (@(posedge clock) disable iff (!nrst)
      ##1 fast_load_threshold_sel == $past(opt3[CPBC_B_FAST_THR]))
      else $error("fast threshold select not following register");
   AST_STAT_RD: assert property (@(posedge clock) disable iff (!nrst)
      rd_en && addr == CPBC_ADDR_OPT3 |=> rdata[CPBC_B_BOOST_STAT] == $past(boost_active))
      else $error("status bit mismatch");
endmodule : cpbc_top

/* verification/cpbc_top_test.sv */
// Self-checking bench for the protection and boost option register block
`timescale 1ns/1ps
module cpbc_top_test;
   import cpbc_pkg::*;
   logic        clock = 1'b0;
   logic        nrst = 1'b0;
   logic        wr_en = 1'b0;
   logic        rd_en = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic        battery_present_n = 1'b0;
   logic        fast_load_over = 1'b0;
   logic        aoc_cmp = 1'b0;
   logic        hs_cmp = 1'b0;
   logic        ls_cmp = 1'b0;
   logic [15:0] rdata;
   logic        limit_sel, fast_sel, aoc_fault, hs_fault, ls_fault, cyc_lim, boost_active;
   logic [4:0]  crit;
   logic [1:0]  code_tab [4] = '{2'h2, 2'h3, 2'h0, 2'h1};
   logic [15:0] cf;
   int          err_count = 0;
   int          checked = 0;
   int          cnt;
   int          n;

   // Free-running 100 MHz clock
   always #5 clock = ~clock;

   cpbc_top u_cpbc_top (.clock(clock), .nrst(nrst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
      .battery_present_n(battery_present_n), .fast_load_over(fast_load_over),
      .adapter_overcurrent_cmp(aoc_cmp), .high_side_short_cmp(hs_cmp), .low_side_short_cmp(ls_cmp),
      .rdata(rdata), .adapter_overcurrent_limit_sel(limit_sel), .fast_load_threshold_sel(fast_sel),
      .critical_input_current(crit), .adapter_overcurrent_fault(aoc_fault), .high_side_short_fault(hs_fault),
      .low_side_short_fault(ls_fault), .cycle_limit_active(cyc_lim), .boost_active(boost_active));

   // Compare one value, four-state exact
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t ns: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   // Inputs always move 1 ns after a rising edge
   task automatic step(input int k);
      repeat (k) @(posedge clock);
      #1;
   endtask : step

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      wr_en = 1'b1;
      addr  = a;
      wdata = d;
      step(1);
      wr_en = 1'b0;
   endtask : wr

   // Read data is sampled a full cycle after the taking edge, where it is settled
   task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string what);
      rd_en = 1'b1;
      addr  = a;
      step(1);
      rd_en = 1'b0;
      step(1);
      chk(rdata, exp, what);
   endtask : rd

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : close_out

   // Boost entry wait for a response code
   function automatic int exp_cnt(input logic [1:0] c);
      return c[1] ? CPBC_CNT50 : (c[0] ? CPBC_CNT250 : CPBC_CNT150);
   endfunction : exp_cnt

   // Watchdog sized well past the longest boost walk
   initial begin
      #1000000;
      err_count++;
      $display("[FAIL] %0t ns: watchdog expired", $time);
      close_out();
   end

   initial begin
      step(2);
      nrst = 1'b1;
      chk(limit_sel, 1'b1, "limit sel reset");
      chk(fast_sel, 1'b0, "fast sel reset");
      chk(crit, CPBC_CRIT_RST, "critical reset");
      chk(boost_active, 1'b0, "boost reset");
      rd(CPBC_ADDR_OPT3, 16'h0240, "opt3 reset");
      rd(CPBC_ADDR_THR0, 16'h4a54, "thr0 reset");
      // Reserved and status bits ignore writes
      wr(CPBC_ADDR_OPT3, 16'hffff);
      rd(CPBC_ADDR_OPT3, 16'h06fc, "opt3 all ones");
      chk(fast_sel, 1'b1, "fast sel set");
      wr(CPBC_ADDR_OPT3, 16'h0000);
      step(1);
      chk(limit_sel, 1'b0, "limit sel 125");
      chk(fast_sel, 1'b0, "fast sel clear");
      // Faults stay quiet while disarmed
      aoc_cmp = 1'b1;
      hs_cmp  = 1'b1;
      ls_cmp  = 1'b1;
      step(2);
      chk({aoc_fault, hs_fault, ls_fault}, 3'b000, "faults disarmed");
      wr(CPBC_ADDR_OPT3, 16'h04c0);
      step(2);
      chk({aoc_fault, hs_fault, ls_fault}, 3'b111, "faults armed");
      aoc_cmp = 1'b0;
      hs_cmp  = 1'b0;
      ls_cmp  = 1'b0;
      step(2);
      chk({aoc_fault, hs_fault, ls_fault}, 3'b000, "faults released");
      // Throttle word, then an unmapped command
      wr(CPBC_ADDR_THR0, 16'hffff);
      rd(CPBC_ADDR_THR0, 16'hfefe, "thr0 all ones");
      chk(crit, 5'h1f, "critical max");
      wr(8'h10, 16'hffff);
      rd(8'h10, 16'h0000, "unmapped read");
      // Boost entry for every response code, removal on the last
      for (int i = 0; i < 4; i++) begin
         cf = {11'h000, code_tab[i], 3'h0};
         n  = exp_cnt(code_tab[i]);
         wr(CPBC_ADDR_OPT3, 16'h0244 | cf);
         fast_load_over = 1'b1;
         cnt = 0;
         while (boost_active !== 1'b1 && cnt < 30000) begin
            step(1);
            cnt++;
         end
         checked++;
         if (cnt < n + 1 || cnt > n + 3) begin
            err_count++;
            $display("[FAIL] %0t ns: boost after %0d cycles, expected about %0d", $time, cnt, n + 2);
         end
         chk(cyc_lim, 1'b1, "cycle limit in boost");
         rd(CPBC_ADDR_OPT3, 16'h0246 | cf, "status in boost");
         if (i == 0) begin
            wr(CPBC_ADDR_OPT3, 16'h0204 | cf);
            step(1);
            chk({boost_active, cyc_lim}, 2'b10, "cycle limit off");
         end
         if (i < 3) begin
            fast_load_over = 1'b0;
            step(2);
            chk(boost_active, 1'b0, "boost exit");
         end else begin
            battery_present_n = 1'b1;
            step(3);
            chk(boost_active, 1'b0, "boost after removal");
            rd(CPBC_ADDR_OPT3, 16'h0240 | cf, "enable cleared");
            fast_load_over    = 1'b0;
            battery_present_n = 1'b0;
         end
      end
      close_out();
   end
endmodule : cpbc_top_test
